//--- hw/wds_map.svh
// Purpose: Address map, field positions, reset values and timing counts
// Assumes: 100 MHz pclk, APB byte addresses
// Notes:   Definitions only
`ifndef WDS_MAP_SVH
`define WDS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WDS_ADDR_W 16
`define WDS_OFF_SWITCH 16'h820c
`define WDS_OFF_CTRL 16'h8210
`define WDS_OFF_TIMEOUT 16'h8214
`define WDS_OFF_STATUS 16'h8218
`define WDS_OFF_OPTION 16'h821c
`define WDS_OFF_IRQ_STAT 16'h8220
`define WDS_OFF_IRQ_MASK 16'h8224

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDS_CTRL_RUN 0
`define WDS_CTRL_ACT 1
`define WDS_CTRL_LOCK 2
`define WDS_CTRL_KICK 3
`define WDS_IRQ_EXPIRY 0
`define WDS_IRQ_SYSRST 1
`define WDS_IRQ_W 2

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define WDS_CODE_HW_RESET 8'ha5
`define WDS_CODE_PWR_RESET 8'h5a
// Arbitrary identity value
`define WDS_OPTION_ID 8'h3c
`define WDS_TIMEOUT_RST 3'h0
`define WDS_MASK_RST 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDS_CLK_PERIOD_NS 10
`define WDS_TICK_MS 100
`define WDS_T_ODD_MS 100
`define WDS_T_EVEN_MS 1000
`define WDS_T_SEL1_MS 4000
`define WDS_PULSE_NS 160
`define WDS_PULSE_CYC (`WDS_PULSE_NS / `WDS_CLK_PERIOD_NS)
`define WDS_TICK_CYC ((`WDS_TICK_MS * 1000000) / `WDS_CLK_PERIOD_NS)

`endif

//--- hw/wds_pkg.sv
// Purpose: Shared types of the watchdog supervisor
// Assumes: Constants live in wds_map.svh
// Notes:   Types only
package wds_pkg;

  // ----------------------------------------
  // Expiry action
  // ----------------------------------------
  typedef enum logic {
    WDS_ACT_RESET,
    WDS_ACT_NMI
  } wds_action_t;

  // ----------------------------------------
  // Supervisor state
  // ----------------------------------------
  typedef enum logic [1:0] {
    WDS_IDLE,
    WDS_RUN,
    WDS_FIRE
  } wds_state_t;

endpackage : wds_pkg

//--- hw/wds_timebase.sv
// Purpose: Prescaler giving one tick per timeout unit
// Assumes: Synchronous restart input
// Notes:   Restart also zeroes the prescaler, so a kick restarts cleanly
`timescale 1ns/1ps
module wds_timebase #(
  parameter int unsigned CYCLES = 1000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic restart,
  // Tick
  output logic tick
);
  logic [31:0] pre_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 32'h0;
    end else if (restart || pre_r == CYCLES - 1) begin
      pre_r <= 32'h0;
    end else begin
      pre_r <= pre_r + 32'h1;
    end
  end

  assign tick = !restart && (pre_r == CYCLES - 1);
endmodule : wds_timebase

//--- hw/wds_top.sv
// Purpose: Watchdog supervisor with APB registers
// Assumes: presetn is the power-on reset and is not driven by sys_reset
// Notes:   Expiry flag survives the reset request it causes
`timescale 1ns/1ps
`include "wds_map.svh"
module wds_top import wds_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `WDS_TICK_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration switch
  input wire logic [3:0] config_switch,
  // System requests
  output logic sys_reset,
  output logic power_reset,
  output logic nmi,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic run_enable_r;
  wds_action_t expiry_action_select_r;
  logic disable_lock_r;
  logic [2:0] timeout_select_r;
  logic expiry_flag_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [11:0] cnt_r;
  logic [11:0] limit;
  logic [4:0] rst_cnt_r;
  logic [4:0] pwr_cnt_r;
  logic [4:0] nmi_cnt_r;
  logic run_q_r;
  wds_state_t state_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic setup_acc;
  logic done;
  logic wr;
  logic wr_ctrl;
  logic wr_opt;
  logic kick;
  logic hw_req;
  logic pwr_req;
  logic tick;
  logic expire;
  logic rearm;
  logic fire_rst;
  logic fire_nmi;
  logic clr_run;
  logic hit;
  logic [31:0] rdata;
  logic [15:0] addr;

  assign addr = paddr[15:0];

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  // One wait state keeps read data and pready both flopped
  assign setup_acc = psel && penable && !pready_r;
  assign done = psel && penable && pready_r;
  assign wr = done && pwrite && !pslverr_r && pstrb[0];
  assign wr_ctrl = wr && addr == `WDS_OFF_CTRL;
  assign wr_opt = wr && addr == `WDS_OFF_OPTION;
  assign kick = wr_ctrl && pwdata[`WDS_CTRL_KICK];
  assign hw_req = wr_opt && pwdata[7:0] == `WDS_CODE_HW_RESET;
  assign pwr_req = wr_opt && pwdata[7:0] == `WDS_CODE_PWR_RESET;

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0;
    case (addr)
      `WDS_OFF_SWITCH: rdata = {28'h0, config_switch};
      `WDS_OFF_CTRL: rdata = {29'h0, disable_lock_r,
                              expiry_action_select_r, run_enable_r};
      `WDS_OFF_TIMEOUT: rdata = {29'h0, timeout_select_r};
      `WDS_OFF_STATUS: rdata = {31'h0, expiry_flag_r};
      `WDS_OFF_OPTION: rdata = {24'h0, `WDS_OPTION_ID};
      `WDS_OFF_IRQ_STAT: rdata = {30'h0, irq_stat_r};
      `WDS_OFF_IRQ_MASK: rdata = {30'h0, irq_mask_r};
      default: hit = 1'b0;
    endcase
    // Mirror is read only; a write there is refused
    if (pwrite && addr == `WDS_OFF_SWITCH) begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup_acc;
      if (setup_acc) begin
        pslverr_r <= !hit;
        prdata_r <= (pwrite || !hit) ? 32'h0 : rdata;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // A reset request returns the run and lock bits to disarmed,
  // as the rest of the system would see after its reset
  assign clr_run = fire_rst || hw_req || pwr_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_enable_r <= 1'b0;
    end else if (clr_run) begin
      run_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      if (pwdata[`WDS_CTRL_RUN] || !disable_lock_r) begin
        run_enable_r <= pwdata[`WDS_CTRL_RUN];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disable_lock_r <= 1'b0;
    end else if (clr_run) begin
      disable_lock_r <= 1'b0;
    end else if (wr_ctrl && pwdata[`WDS_CTRL_LOCK]) begin
      disable_lock_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expiry_action_select_r <= WDS_ACT_RESET;
    end else if (wr_ctrl) begin
      expiry_action_select_r <= wds_action_t'(pwdata[`WDS_CTRL_ACT]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_select_r <= `WDS_TIMEOUT_RST;
    end else if (wr && addr == `WDS_OFF_TIMEOUT) begin
      timeout_select_r <= pwdata[2:0];
    end
  end

  // ----------------------------------------
  // Timeout decode and count
  // ----------------------------------------
  always_comb begin
    int unsigned ms;
    ms = 0;
    if (timeout_select_r == 3'h0) begin
      ms = config_switch[0] ? `WDS_T_ODD_MS : `WDS_T_EVEN_MS;
    end else begin
      ms = `WDS_T_SEL1_MS << (timeout_select_r - 3'h1);
    end
    limit = 12'(ms / `WDS_TICK_MS);
  end

  wds_timebase #(
    .CYCLES(TICK_CYCLES)
  ) u_timebase (
    .pclk(pclk),
    .presetn(presetn),
    .restart(kick || state_r != WDS_RUN),
    .tick(tick)
  );

  // At or past the limit, so a timeout shortened mid-run still fires
  assign expire = state_r == WDS_RUN && tick && cnt_r >= limit - 12'h1;
  assign rearm = run_enable_r && !run_q_r && expiry_flag_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 12'h0;
    end else if (kick || state_r != WDS_RUN || expire) begin
      cnt_r <= 12'h0;
    end else if (tick) begin
      cnt_r <= cnt_r + 12'h1;
    end
  end

  // ----------------------------------------
  // Supervisor state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= WDS_IDLE;
      run_q_r <= 1'b0;
    end else begin
      run_q_r <= run_enable_r;
      case (state_r)
        WDS_IDLE: begin
          if (rearm) begin
            state_r <= WDS_FIRE;
          end else if (run_enable_r) begin
            state_r <= WDS_RUN;
          end
        end
        WDS_RUN: begin
          if (!run_enable_r) begin
            state_r <= WDS_IDLE;
          end else if (expire) begin
            state_r <= WDS_FIRE;
          end
        end
        WDS_FIRE: begin
          state_r <= run_enable_r && !fire_rst ? WDS_RUN : WDS_IDLE;
        end
        default: state_r <= WDS_IDLE;
      endcase
    end
  end

  assign fire_rst = state_r == WDS_FIRE &&
                    expiry_action_select_r == WDS_ACT_RESET;
  assign fire_nmi = state_r == WDS_FIRE &&
                    expiry_action_select_r == WDS_ACT_NMI;

  // ----------------------------------------
  // Expiry flag
  // ----------------------------------------
  // Set wins over a same-cycle clear so an expiry is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expiry_flag_r <= 1'b0;
    end else if (expire) begin
      expiry_flag_r <= 1'b1;
    end else if (hw_req || pwr_req) begin
      expiry_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Request pulses
  // ----------------------------------------
  // Stretched so slow reset logic sees them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_r <= 5'h0;
    end else if (fire_rst || hw_req) begin
      rst_cnt_r <= 5'(`WDS_PULSE_CYC);
    end else if (rst_cnt_r != 5'h0) begin
      rst_cnt_r <= rst_cnt_r - 5'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_cnt_r <= 5'h0;
    end else if (pwr_req) begin
      pwr_cnt_r <= 5'(`WDS_PULSE_CYC);
    end else if (pwr_cnt_r != 5'h0) begin
      pwr_cnt_r <= pwr_cnt_r - 5'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_cnt_r <= 5'h0;
    end else if (fire_nmi) begin
      nmi_cnt_r <= 5'(`WDS_PULSE_CYC);
    end else if (nmi_cnt_r != 5'h0) begin
      nmi_cnt_r <= nmi_cnt_r - 5'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset <= 1'b0;
      power_reset <= 1'b0;
      nmi <= 1'b0;
    end else begin
      sys_reset <= fire_rst || hw_req || rst_cnt_r > 5'h1;
      power_reset <= pwr_req || pwr_cnt_r > 5'h1;
      nmi <= fire_nmi || nmi_cnt_r > 5'h1;
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 2'h0;
    end else begin
      for (int i = 0; i < `WDS_IRQ_W; i++) begin
        if (wr && addr == `WDS_OFF_IRQ_STAT && pwdata[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
      // Events placed last so set beats clear
      if (expire) begin
        irq_stat_r[`WDS_IRQ_EXPIRY] <= 1'b1;
      end
      if (fire_rst || hw_req || pwr_req) begin
        irq_stat_r[`WDS_IRQ_SYSRST] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= `WDS_MASK_RST;
      irq_r <= 1'b0;
    end else begin
      if (wr && addr == `WDS_OFF_IRQ_MASK) begin
        irq_mask_r <= pwdata[1:0];
      end
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign irq = irq_r;

endmodule : wds_top

//--- testbench/wds_host_model.sv
// Purpose: Host side that takes reset, NMI and power requests
// Assumes: Requests are pulses
// Notes:   Counts only; widths are checked elsewhere
`timescale 1ns/1ps
module wds_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests
  input wire logic sys_reset,
  input wire logic nmi,
  input wire logic power_reset,
  // Counts
  output int n_rst,
  output int n_nmi,
  output int n_pwr
);
  logic [2:0] last_r;
  // Requested resets must not wipe the counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= 3'h0;
      n_rst <= 0;
      n_nmi <= 0;
      n_pwr <= 0;
    end else begin
      last_r <= {power_reset, nmi, sys_reset};
      n_rst <= n_rst + int'(sys_reset && !last_r[0]);
      n_nmi <= n_nmi + int'(nmi && !last_r[1]);
      n_pwr <= n_pwr + int'(power_reset && !last_r[2]);
    end
  end
endmodule : wds_host_model

//--- testbench/wds_top_sva.sv
// Purpose: Port checks of the watchdog supervisor
// Assumes: One clock domain
// Notes:   Bound to wds_top
`timescale 1ns/1ps
`include "wds_map.svh"
module wds_top_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Requests
  input wire logic sys_reset,
  input wire logic power_reset,
  input wire logic nmi
);
  logic wr_c;
  logic seen_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr_c = psel && penable && pready && pwrite && pstrb[0];
  // Any completed write with pstrb[0] set counts as software activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= 1'b0;
    end else if (wr_c) begin
      seen_r <= 1'b1;
    end
  end
  // ----
  // Properties
  // ----
  property p_idle;
    !seen_r |-> !sys_reset && !nmi && !power_reset;
  endproperty
  a_idle: assert property (p_idle) else $error("request before arming");
  property p_up0;
    pready && !pwrite && paddr[15:0] == `WDS_OFF_SWITCH |-> !prdata[31:4];
  endproperty
  a_up0: assert property (p_up0) else $error("switch upper bits set");
  property p_swwr;
    pready && pwrite && paddr[15:0] == `WDS_OFF_SWITCH |-> pslverr;
  endproperty
  a_swwr: assert property (p_swwr) else $error("switch write taken");
  property p_rstw;
    $rose(sys_reset) |-> sys_reset[*8] ##1 sys_reset[*8] ##1 !sys_reset;
  endproperty
  a_rstw: assert property (p_rstw) else $error("reset pulse width");
  property p_nmiw;
    $rose(nmi) |-> nmi[*8] ##1 nmi[*8] ##1 !nmi;
  endproperty
  a_nmiw: assert property (p_nmiw) else $error("nmi pulse width");
  property p_pwrw;
    $rose(power_reset) |-> power_reset[*8] ##1 power_reset[*8]
      ##1 !power_reset;
  endproperty
  a_pwrw: assert property (p_pwrw) else $error("power pulse width");
  property p_a5;
    wr_c && paddr[15:0] == `WDS_OFF_OPTION
      && pwdata[7:0] == `WDS_CODE_HW_RESET |-> ##[1:4] sys_reset;
  endproperty
  a_a5: assert property (p_a5) else $error("no reset on code");
  property p_5a;
    wr_c && paddr[15:0] == `WDS_OFF_OPTION
      && pwdata[7:0] == `WDS_CODE_PWR_RESET |-> ##[1:4] power_reset;
  endproperty
  a_5a: assert property (p_5a) else $error("no power reset on code");
  c_rst: cover property ($rose(sys_reset));
  c_nmi: cover property ($rose(nmi));
  c_pwr: cover property ($rose(power_reset));
endmodule : wds_top_sva

bind wds_top wds_top_sva wds_top_sva_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sys_reset(sys_reset), .power_reset(power_reset),
  .nmi(nmi));

//--- testbench/wds_top_tb.sv
// Purpose: Self-checking bench of the watchdog supervisor
// Assumes: TICK_CYCLES of 10, so 100 ms is 10 cycles
// Notes:   One transfer in flight at a time
`timescale 1ns/1ps
`include "wds_map.svh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin n_errors++; \
  $display("wrong value %0t %h %h", $time, g, x); end end
module wds_top_tb import wds_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [3:0] pstrb, config_switch;
  logic sys_reset, power_reset, nmi, irq;
  int n_errors, compares, cyc, n_rst, n_nmi, n_pwr;
  wds_top #(.TICK_CYCLES(10)) wds_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .config_switch(config_switch), .irq(irq),
    .sys_reset(sys_reset), .power_reset(power_reset), .nmi(nmi));
  wds_host_model wds_host_model_inst (.pclk(pclk), .presetn(presetn),
    .sys_reset(sys_reset), .nmi(nmi), .power_reset(power_reset),
    .n_rst(n_rst), .n_nmi(n_nmi), .n_pwr(n_pwr));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Whole run is about 2700 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic stop_test();
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {16'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : acc
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    `CHK(e, 1'b0)
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  // ----
  // Sequence
  // ----
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h1;
    config_switch = 4'h9;
    wt(6);
    presetn <= 1'b1;
    wt(1);
    rd(`WDS_OFF_CTRL, 32'h0);
    rd(`WDS_OFF_STATUS, 32'h0);
    rd(`WDS_OFF_OPTION, {24'h0, `WDS_OPTION_ID});
    acc(1'b1, `WDS_OFF_SWITCH, 32'hf);
    `CHK(e, 1'b1)
    rd(`WDS_OFF_SWITCH, 32'h9);
    acc(1'b0, 16'h8228, 32'h0);
    `CHK(e, 1'b1)
    for (int i = 7; i >= 0; i--) begin
      wr(`WDS_OFF_TIMEOUT, 32'(i));
      rd(`WDS_OFF_TIMEOUT, 32'(i));
    end
    wt(60);
    `CHK(n_rst, 0)
    wr(`WDS_OFF_CTRL, 32'h1);
    wt(40);
    `CHK(n_rst, 1)
    rd(`WDS_OFF_STATUS, 32'h1);
    rd(`WDS_OFF_IRQ_STAT, 32'h3);
    wr(`WDS_OFF_CTRL, 32'h1);
    wt(30);
    `CHK(n_rst, 2)
    wr(`WDS_OFF_OPTION, {24'h0, `WDS_CODE_HW_RESET});
    wt(30);
    `CHK(n_rst, 3)
    rd(`WDS_OFF_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    wr(`WDS_OFF_IRQ_MASK, 32'h3);
    wt(2);
    `CHK(irq, 1'b1)
    wr(`WDS_OFF_IRQ_STAT, 32'h3);
    wt(2);
    `CHK(irq, 1'b0)
    config_switch <= 4'h4;
    wr(`WDS_OFF_CTRL, 32'h2);
    rd(`WDS_OFF_SWITCH, 32'h4);
    wr(`WDS_OFF_CTRL, 32'h3);
    wt(80);
    `CHK(n_nmi, 0)
    wt(40);
    `CHK(n_nmi, 1)
    `CHK(n_rst, 3)
    wr(`WDS_OFF_CTRL, 32'h2);
    wr(`WDS_OFF_CTRL, 32'h3);
    wt(8);
    `CHK(n_nmi, 2)
    wr(`WDS_OFF_OPTION, {24'h0, `WDS_CODE_PWR_RESET});
    wt(30);
    `CHK(n_pwr, 1)
    rd(`WDS_OFF_STATUS, 32'h0);
    wr(`WDS_OFF_TIMEOUT, 32'h1);
    wr(`WDS_OFF_CTRL, 32'h5);
    repeat (3) begin
      wt(300);
      wr(`WDS_OFF_CTRL, 32'h9);
    end
    `CHK(n_rst, 3)
    wr(`WDS_OFF_CTRL, 32'h0);
    rd(`WDS_OFF_CTRL, 32'h5);
    wt(360);
    `CHK(n_rst, 3)
    wt(60);
    `CHK(n_rst, 4)
    wr(`WDS_OFF_OPTION, {24'h0, `WDS_CODE_HW_RESET});
    wt(30);
    `CHK(n_rst, 5)
    wr(`WDS_OFF_TIMEOUT, 32'h2);
    wr(`WDS_OFF_CTRL, 32'h1);
    wt(780);
    `CHK(n_rst, 5)
    wt(40);
    `CHK(n_rst, 6)
    stop_test();
  end
endmodule : wds_top_tb
